// ---- verilog/pic_ctrl.sv ----
// Proportional-integral process controller with an AXI4-Lite register file
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int SAMPLE_CYCLES = pic_pkg::SAMPLE_CYC
)(
  input wire logic aclk, // Clock, 125 MHz
  input wire logic aresetn, // Synchronous reset
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [pic_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused protection
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  output logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  input wire logic [pic_pkg::AXI_AW-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused protection
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  input wire logic signed [15:0] process_value, // Raw analog input
  input wire logic signed [15:0] setpoint_ext, // Setpoint from another block
  input wire logic signed [15:0] manual_ext, // Manual value from another block
  output logic [15:0] manipulated_output, // Output, 0 to 1000
  output logic sample_tick // One cycle per sampling interval
);
  import pic_pkg::*;

  function automatic int pic_clamp(input int v, input int lo, input int hi);
    if (v > hi)
      return hi;
    else if (v < lo)
      return lo;
    return v;
  endfunction : pic_clamp

  // Merge the two low byte lanes into a 16-bit field
  function automatic int pic_wr16(input logic [15:0] old, input logic [31:0] wd,
                                  input logic [3:0] ws);
    logic [15:0] r;
    r = old;
    if (ws[0])
      r[7:0] = wd[7:0];
    if (ws[1])
      r[15:8] = wd[15:8];
    return int'($signed(r));
  endfunction : pic_wr16

  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rdata_d;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q, rresp_d;
  logic do_wr, wr_ok;
  logic [CTRL_W-1:0] ctrl_q;
  logic signed [15:0] sp_q, kc_q, ti_q, mq_q, min_q, max_q, ag_q, ofs_q;
  logic signed [15:0] pvs_q, sp_eff, mq_eff;
  logic [15:0] mo_q;
  logic [31:0] cnt_q;
  logic tick;
  pic_mode_t mode_q;
  logic dir_run_q, dir_eff;
  logic signed [47:0] acc_q, acc_nxt;
  int err, eprev_q, pvs_d;

  // Bus slave: address and data are taken in either order
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign do_wr = aw_q && w_q && !bvalid_q;

  always_comb
  begin
    wr_ok = 1'b0;
    if (awaddr_q == ADR_CTRL || awaddr_q == ADR_SETPOINT || awaddr_q == ADR_LOOP_GAIN)
      wr_ok = 1'b1;
    else if (awaddr_q == ADR_INT_TIME || awaddr_q == ADR_MANUAL || awaddr_q == ADR_PV_MIN)
      wr_ok = 1'b1;
    else if (awaddr_q == ADR_PV_MAX || awaddr_q == ADR_IN_GAIN || awaddr_q == ADR_IN_OFS)
      wr_ok = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[AXI_AW-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Writes saturate to each 16-bit field's legal range rather than being refused; the control register keeps the low CTRL_W bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= RST_CTRL;
      sp_q <= RST_SETPOINT;
      kc_q <= RST_LOOP_GAIN;
      ti_q <= RST_INT_TIME;
      mq_q <= RST_MANUAL;
      min_q <= RST_PV_MIN;
      max_q <= RST_PV_MAX;
      ag_q <= RST_IN_GAIN;
      ofs_q <= RST_IN_OFS;
    end
    else if (do_wr)
    begin
      if (awaddr_q == ADR_CTRL && wstrb_q[0])
        ctrl_q <= wdata_q[CTRL_W-1:0];
      else if (awaddr_q == ADR_SETPOINT)
        sp_q <= 16'(pic_clamp(pic_wr16(sp_q, wdata_q, wstrb_q), VAL_MIN, VAL_MAX));
      else if (awaddr_q == ADR_LOOP_GAIN)
        kc_q <= 16'(pic_clamp(pic_wr16(kc_q, wdata_q, wstrb_q), 0, KC_MAX));
      else if (awaddr_q == ADR_INT_TIME)
        ti_q <= 16'(pic_clamp(pic_wr16(ti_q, wdata_q, wstrb_q), TI_MIN, TI_OFF));
      else if (awaddr_q == ADR_MANUAL)
        mq_q <= 16'(pic_clamp(pic_wr16(mq_q, wdata_q, wstrb_q), 0, OUT_MAX));
      else if (awaddr_q == ADR_PV_MIN)
        min_q <= 16'(pic_clamp(pic_wr16(min_q, wdata_q, wstrb_q), VAL_MIN, VAL_MAX));
      else if (awaddr_q == ADR_PV_MAX)
        max_q <= 16'(pic_clamp(pic_wr16(max_q, wdata_q, wstrb_q), VAL_MIN, VAL_MAX));
      else if (awaddr_q == ADR_IN_GAIN)
        ag_q <= 16'(pic_clamp(pic_wr16(ag_q, wdata_q, wstrb_q), AG_MIN, AG_MAX));
      else if (awaddr_q == ADR_IN_OFS)
        ofs_q <= 16'(pic_clamp(pic_wr16(ofs_q, wdata_q, wstrb_q), OFS_MIN, OFS_MAX));
    end
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    rresp_d = RESP_OKAY;
    if (s_axi_araddr[AXI_AW-1:2] == ADR_CTRL[7:2])
      rdata_d = {27'h0000000, ctrl_q};
    else if (s_axi_araddr[AXI_AW-1:2] == ADR_SETPOINT[7:2])
      rdata_d = {16'h0000, sp_q};
    else if (s_axi_araddr[AXI_AW-1:2] == ADR_LOOP_GAIN[7:2])
      rdata_d = {16'h0000, kc_q};
    else if (s_axi_araddr[AXI_AW-1:2] == ADR_INT_TIME[7:2])
      rdata_d = {16'h0000, ti_q};
    else if (s_axi_araddr[AXI_AW-1:2] == ADR_MANUAL[7:2])
      rdata_d = {16'h0000, mq_q};
    else if (s_axi_araddr[AXI_AW-1:2] == ADR_PV_MIN[7:2])
      rdata_d = {16'h0000, min_q};
    else if (s_axi_araddr[AXI_AW-1:2] == ADR_PV_MAX[7:2])
      rdata_d = {16'h0000, max_q};
    else if (s_axi_araddr[AXI_AW-1:2] == ADR_IN_GAIN[7:2])
      rdata_d = {16'h0000, ag_q};
    else if (s_axi_araddr[AXI_AW-1:2] == ADR_IN_OFS[7:2])
      rdata_d = {16'h0000, ofs_q};
    else if (s_axi_araddr[AXI_AW-1:2] == ADR_OUT[7:2])
      rdata_d = {15'h0000, mode_q == PIC_AUTO, mo_q};
    else if (s_axi_araddr[AXI_AW-1:2] == ADR_PV_SCALED[7:2])
      rdata_d = {16'h0000, pvs_q};
    else
      rresp_d = RESP_SLVERR;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // Setpoint and manual value from a register or another block
  assign sp_eff = ctrl_q[CTRL_SP_EXT] ? 16'(pic_clamp(int'(setpoint_ext), VAL_MIN, VAL_MAX)) : sp_q;
  assign mq_eff = ctrl_q[CTRL_MQ_EXT] ? 16'(pic_clamp(int'(manual_ext), 0, OUT_MAX)) : mq_q;

  // Input scaling and clamp; an inverted limit pair lets the upper limit win
  always_comb
  begin
    pvs_d = int'(process_value) * int'(ag_q) / KC_ONE + int'(ofs_q);
    pvs_d = pic_clamp(pvs_d, int'(min_q), int'(max_q));
    if (pvs_d > int'(max_q))
      pvs_d = int'(max_q);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pvs_q <= '0;
    else
      pvs_q <= 16'(pvs_d);
  end

  // Free-running sampling timer
  assign tick = cnt_q == 32'(SAMPLE_CYCLES - 1);
  assign sample_tick = tick;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 32'h0000_0001;
  end

  // Direction is frozen while automatic so a runtime change cannot flip the loop
  assign dir_eff = (mode_q == PIC_AUTO) ? dir_run_q : ctrl_q[CTRL_DIR];
  assign err = dir_eff ? int'(pvs_q) - int'(sp_eff) : int'(sp_eff) - int'(pvs_q);

  // Velocity form; the accumulator is clamped, which also stops wind-up
  always_comb
  begin
    longint p_fix, i_fix, kc_i, sum;
    p_fix = 0;
    i_fix = 0;
    sum = 0;
    kc_i = (kc_q == 16'sh0000) ? longint'(KC_ONE) : longint'(kc_q);
    if (kc_q != 16'sh0000)
      p_fix = longint'(kc_q) * longint'(err - eprev_q) * FRAC_ONE / KC_ONE;
    if (ti_q != 16'(TI_OFF))
      i_fix = kc_i * longint'(err) * FRAC_ONE / (I_DIV * longint'(ti_q));
    sum = longint'(acc_q) + p_fix + i_fix;
    if (sum > longint'(OUT_MAX) * FRAC_ONE)
      sum = longint'(OUT_MAX) * FRAC_ONE;
    else if (sum < 0)
      sum = 0;
    acc_nxt = 48'(sum);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q <= PIC_MANUAL;
      acc_q <= '0;
      eprev_q <= 0;
      dir_run_q <= 1'b0;
    end
    else if (ctrl_q[CTRL_RST])
    begin
      mode_q <= PIC_MANUAL;
      acc_q <= '0;
    end
    else
    begin
      case (mode_q)
        PIC_MANUAL:
          if (ctrl_q[CTRL_AUTO])
          begin
            mode_q <= PIC_AUTO;
            acc_q <= 48'(longint'(mq_eff) * FRAC_ONE);
            eprev_q <= err;
            dir_run_q <= ctrl_q[CTRL_DIR];
          end
        PIC_AUTO:
          if (!ctrl_q[CTRL_AUTO])
            mode_q <= PIC_MANUAL;
          else if (tick && err != 0)
          begin
            acc_q <= acc_nxt;
            eprev_q <= err;
          end
          else if (tick)
            eprev_q <= 0;
        default:
          mode_q <= PIC_MANUAL;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || ctrl_q[CTRL_RST])
      mo_q <= '0;
    else if (mode_q == PIC_AUTO)
      mo_q <= 16'(acc_q >>> FRAC);
    else
      mo_q <= mq_eff;
  end

  assign manipulated_output = mo_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  out_range_a: assert property (mo_q <= 16'(OUT_MAX))
    else $error("output above upper bound");
  reset_zero_a: assert property (ctrl_q[CTRL_RST] |=> mo_q == 16'h0000 && mode_q == PIC_MANUAL)
    else $error("reset did not clear output");
  manual_out_a: assert property (mode_q == PIC_MANUAL && !ctrl_q[CTRL_RST] |=> mo_q == $past(mq_eff))
    else $error("manual output mismatch");
  auto_seed_a: assert property (mode_q == PIC_MANUAL && ctrl_q[CTRL_AUTO] && !ctrl_q[CTRL_RST]
    |=> mode_q == PIC_AUTO ##1 mo_q == 16'($past(mq_eff, 2)))
    else $error("integral not seeded on auto entry");
  hold_equal_a: assert property (mode_q == PIC_AUTO && tick && err == 0 && ctrl_q[CTRL_AUTO]
    && !ctrl_q[CTRL_RST] |=> $stable(acc_q))
    else $error("output moved at setpoint");
  up_raise_a: assert property (mode_q == PIC_AUTO && ctrl_q[CTRL_AUTO] && !ctrl_q[CTRL_RST] && tick
    && !dir_run_q && pvs_q < sp_eff && kc_q == 16'sh0000 && ti_q != 16'(TI_OFF)
    |=> acc_q >= $past(acc_q))
    else $error("upward action did not raise output");
  down_lower_a: assert property (mode_q == PIC_AUTO && ctrl_q[CTRL_AUTO] && !ctrl_q[CTRL_RST] && tick
    && dir_run_q && pvs_q < sp_eff && kc_q == 16'sh0000 && ti_q != 16'(TI_OFF)
    |=> acc_q <= $past(acc_q))
    else $error("downward action did not lower output");
  pv_clamp_a: assert property (min_q <= max_q |=> pvs_q >= $past(min_q) && pvs_q <= $past(max_q))
    else $error("scaled value outside limits");
  dir_fixed_a: assert property (mode_q == PIC_AUTO && $past(mode_q) == PIC_AUTO |-> $stable(dir_run_q))
    else $error("direction changed while running");
  sample_gap_a: assert property (tick && SAMPLE_CYCLES > 1 |=> !tick && cnt_q == 32'h0000_0000)
    else $error("sample interval broken");
  param_range_a: assert property (kc_q <= 16'(KC_MAX) && ti_q >= 16'(TI_MIN) && ti_q <= 16'(TI_OFF))
    else $error("parameter out of range");

  auto_entry_c: cover property (mode_q == PIC_MANUAL ##1 mode_q == PIC_AUTO);
  reset_in_auto_c: cover property (mode_q == PIC_AUTO && ctrl_q[CTRL_RST]);
  out_top_c: cover property (mode_q == PIC_AUTO && mo_q == 16'(OUT_MAX));
  sample_move_c: cover property (mode_q == PIC_AUTO && tick ##1 !$stable(acc_q));
endmodule : pic_ctrl

// ---- include/pic_pkg.sv ----
// Constants, register map and types of the process controller block
package pic_pkg;
  // Clock and sampling
  localparam int CLK_KHZ = 125000;
  localparam int SAMPLE_MS = 500;
  localparam int SAMPLE_CYC = SAMPLE_MS * CLK_KHZ;
  // Register bus
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SETPOINT = 8'h04;
  localparam logic [7:0] ADR_LOOP_GAIN = 8'h08;
  localparam logic [7:0] ADR_INT_TIME = 8'h0c;
  localparam logic [7:0] ADR_MANUAL = 8'h10;
  localparam logic [7:0] ADR_PV_MIN = 8'h14;
  localparam logic [7:0] ADR_PV_MAX = 8'h18;
  localparam logic [7:0] ADR_IN_GAIN = 8'h1c;
  localparam logic [7:0] ADR_IN_OFS = 8'h20;
  localparam logic [7:0] ADR_OUT = 8'h24;
  localparam logic [7:0] ADR_PV_SCALED = 8'h28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control register fields
  localparam int CTRL_W = 5;
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_RST = 1;
  localparam int CTRL_DIR = 2;
  localparam int CTRL_SP_EXT = 3;
  localparam int CTRL_MQ_EXT = 4;
  // Value ranges; gains are in hundredths, integral time in seconds
  localparam int VAL_MIN = -10000;
  localparam int VAL_MAX = 20000;
  localparam int KC_MAX = 9999;
  localparam int KC_ONE = 100;
  localparam int TI_MIN = 1;
  localparam int TI_OFF = 5999;
  localparam int OUT_MAX = 1000;
  localparam int AG_MIN = -1000;
  localparam int AG_MAX = 1000;
  localparam int OFS_MIN = -10000;
  localparam int OFS_MAX = 10000;
  localparam int FRAC = 16;
  localparam longint FRAC_ONE = 64'sd1 <<< FRAC;
  localparam longint I_DIV = longint'(KC_ONE) * 1000 / SAMPLE_MS;
  // Values after reset
  localparam logic [CTRL_W-1:0] RST_CTRL = 5'h00;
  localparam logic [15:0] RST_SETPOINT = 16'h0000;
  localparam logic [15:0] RST_LOOP_GAIN = 16'h0064;
  localparam logic [15:0] RST_INT_TIME = 16'h176f;
  localparam logic [15:0] RST_MANUAL = 16'h0000;
  localparam logic [15:0] RST_PV_MIN = 16'hd8f0;
  localparam logic [15:0] RST_PV_MAX = 16'h4e20;
  localparam logic [15:0] RST_IN_GAIN = 16'h0064;
  localparam logic [15:0] RST_IN_OFS = 16'h0000;

  typedef enum logic {PIC_MANUAL, PIC_AUTO} pic_mode_t;
endpackage : pic_pkg

// ---- dv/tb_top.sv ----
// Self-checking bench for the process controller block
`timescale 1ns/1ps
module tb_top;
  import pic_pkg::*;
  localparam int SC = 20;
  typedef struct {logic [31:0] m; logic [31:0] e; logic [1:0] r;} pic_note_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wrdy, bv, arr, rv, tick;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, last;
  logic [1:0] bresp, rresp;
  logic signed [15:0] pv = 16'sh0, spx = 16'sh0, mqx = 16'sh0;
  logic [15:0] mo;
  pic_note_t notes[$];
  pic_note_t nt;
  int num_errors = 0;
  int comparisons = 0;
  int p, n;
  logic [7:0] ra[9] = '{ADR_CTRL, ADR_SETPOINT, ADR_LOOP_GAIN, ADR_INT_TIME, ADR_MANUAL,
                        ADR_PV_MIN, ADR_PV_MAX, ADR_IN_GAIN, ADR_IN_OFS};
  logic [15:0] rvl[9] = '{16'(RST_CTRL), RST_SETPOINT, RST_LOOP_GAIN, RST_INT_TIME, RST_MANUAL,
                          RST_PV_MIN, RST_PV_MAX, RST_IN_GAIN, RST_IN_OFS};
  // Out-of-range writes and the value each field saturates to
  logic [7:0] sa[6] = '{ADR_LOOP_GAIN, ADR_INT_TIME, ADR_MANUAL, ADR_PV_MIN, ADR_IN_GAIN, ADR_SETPOINT};
  logic [15:0] sw[6] = '{16'h7fff, 16'h0000, 16'h07d0, 16'h8000, 16'h07d0, 16'h7fff};
  logic [15:0] se[6] = '{16'h270f, 16'h0001, 16'h03e8, 16'hd8f0, 16'h03e8, 16'h4e20};

  always #4 aclk = ~aclk;

  pic_ctrl #(.SAMPLE_CYCLES(SC)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .process_value(pv), .setpoint_ext(spx), .manual_ext(mqx),
    .manipulated_output(mo), .sample_tick(tick));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      num_errors++;
    end
  endtask : chk

  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // Handshakes are judged at the falling edge so the decision matches the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd, bd;
    bd = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!bd)
    begin
      @(negedge aclk);
      ad = awv && awr;
      dd = wv && wrdy;
      bd = bv;
      if (bd)
        chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
      if (ad)
        awv <= 1'b0;
      if (dd)
        wv <= 1'b0;
      if (bd)
        br <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic ok, dn;
    dn = 1'b0;
    notes.push_back('{m, e, er});
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    while (!dn)
    begin
      @(negedge aclk);
      ok = arv && arr;
      dn = rv;
      last = rdat;
      @(posedge aclk);
      if (ok)
        arv <= 1'b0;
      if (dn)
        rr <= 1'b0;
    end
  endtask : rd

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  // Output moves two cycles after a tick, so allow a small margin past the ticks
  task automatic tk(input int k);
    repeat (k * SC + 3) @(posedge aclk);
  endtask : tk

  always @(posedge aclk)
  begin
    if (rv && rr && notes.size() > 0)
    begin
      nt = notes.pop_front();
      chk(rdat & nt.m, nt.e & nt.m);
      chk({30'h0, rresp}, {30'h0, nt.r});
    end
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    finish_test();
  end

  initial
  begin
    void'($urandom(32'h1a3c72c1));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[i])
      rd(ra[i], 32'hffffffff, {16'h0, rvl[i]}, RESP_OKAY);
    rd(ADR_OUT, 32'h1ffff, 32'h0, RESP_OKAY);
    rd(8'h30, 32'hffffffff, 32'h0, RESP_SLVERR);
    wr(ADR_OUT, 32'h1, RESP_SLVERR);
    foreach (sa[i])
    begin
      wr(sa[i], {16'h0, sw[i]}, RESP_OKAY);
      rd(sa[i], 32'hffff, {16'h0, se[i]}, RESP_OKAY);
    end
    wr(ADR_IN_GAIN, 32'hc8, RESP_OKAY);
    wr(ADR_IN_OFS, 32'h64, RESP_OKAY);
    p = int'($urandom_range(8000)) - 4000;
    pv <= 16'(p);
    cyc(3);
    rd(ADR_PV_SCALED, 32'hffff, 32'(2 * p + 100), RESP_OKAY);
    pv <= 16'sd15000;
    cyc(3);
    rd(ADR_PV_SCALED, 32'hffff, 32'h4e20, RESP_OKAY);
    pv <= -16'sd8000;
    cyc(3);
    rd(ADR_PV_SCALED, 32'hffff, 32'hd8f0, RESP_OKAY);
    wr(ADR_IN_GAIN, 32'h64, RESP_OKAY);
    wr(ADR_IN_OFS, 32'h0, RESP_OKAY);
    wr(ADR_MANUAL, 32'h258, RESP_OKAY);
    wr(ADR_CTRL, 32'h0, RESP_OKAY);
    cyc(3);
    rd(ADR_OUT, 32'h1ffff, 32'h258, RESP_OKAY);
    p = int'($urandom_range(1000));
    mqx <= 16'(p);
    wr(ADR_CTRL, 32'h10, RESP_OKAY);
    cyc(3);
    rd(ADR_OUT, 32'h1ffff, 32'(p), RESP_OKAY);
    wr(ADR_CTRL, 32'h0, RESP_OKAY);
    do @(negedge aclk); while (!tick);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (!tick);
    chk(32'(n), 32'(SC));
    wr(ADR_LOOP_GAIN, 32'h64, RESP_OKAY);
    wr(ADR_INT_TIME, 32'h176f, RESP_OKAY);
    wr(ADR_SETPOINT, 32'h1f4, RESP_OKAY);
    pv <= 16'sd500;
    wr(ADR_CTRL, 32'h1, RESP_OKAY);
    tk(2);
    rd(ADR_OUT, 32'h1ffff, 32'h10258, RESP_OKAY);
    pv <= 16'sd400;
    tk(2);
    rd(ADR_OUT, 32'h1ffff, 32'h102bc, RESP_OKAY);
    tk(2);
    rd(ADR_OUT, 32'h1ffff, 32'h102bc, RESP_OKAY);
    wr(ADR_CTRL, 32'h0, RESP_OKAY);
    wr(ADR_LOOP_GAIN, 32'h0, RESP_OKAY);
    wr(ADR_INT_TIME, 32'h1, RESP_OKAY);
    spx <= 16'sd400;
    wr(ADR_CTRL, 32'h9, RESP_OKAY);
    tk(3);
    rd(ADR_OUT, 32'h1ffff, 32'h10258, RESP_OKAY);
    wr(ADR_CTRL, 32'h0, RESP_OKAY);
    pv <= 16'sd300;
    wr(ADR_CTRL, 32'h1, RESP_OKAY);
    tk(2);
    rd(ADR_OUT, 32'h0, 32'h0, RESP_OKAY);
    chk(32'(last[16:0] > 17'h10258 && last[16:0] < 17'h103e8), 32'h1);
    tk(6);
    rd(ADR_OUT, 32'h1ffff, 32'h103e8, RESP_OKAY);
    chk({16'h0, mo}, 32'h3e8);
    wr(ADR_CTRL, 32'h3, RESP_OKAY);
    cyc(3);
    rd(ADR_OUT, 32'h1ffff, 32'h0, RESP_OKAY);
    chk({16'h0, mo}, 32'h0);
    wr(ADR_CTRL, 32'h0, RESP_OKAY);
    // Direction is only changed while the loop is in manual mode
    wr(ADR_CTRL, 32'h5, RESP_OKAY);
    tk(2);
    rd(ADR_OUT, 32'h0, 32'h0, RESP_OKAY);
    chk(32'(last[16:0] < 17'h10258 && last[16:0] >= 17'h10000), 32'h1);
    tk(6);
    rd(ADR_OUT, 32'h1ffff, 32'h10000, RESP_OKAY);
    chk({16'h0, mo}, 32'h0);
    cyc(3);
    finish_test();
  end
endmodule : tb_top
